// ==== core/sbc_pkg.sv ====
/*
  sbc_pkg: constants, register map, field layouts and types shared by the
  holding-brake control block. Assumes a 100 MHz system clock and a 32-bit
  APB bus with one aligned word per register.
*/
package sbc_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] POST_OFF_MS   = 16'h0032;   // motor stays powered after brake drop
  localparam logic [15:0] STATIC_RPM    = 16'h001e;   // static / moving boundary

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_BRK_EN   = 8'h00;
  localparam logic [7:0] OFS_DO_FUNC  = 8'h04;
  localparam logic [7:0] OFS_DO_POL   = 8'h08;
  localparam logic [7:0] OFS_HOLD_MS  = 8'h0c;
  localparam logic [7:0] OFS_CMD_MS   = 8'h10;
  localparam logic [7:0] OFS_SPD_THR  = 8'h14;
  localparam logic [7:0] OFS_WAIT_MS  = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_MOT_STG  = 8'h20;
  localparam logic [7:0] OFS_MOT_ACT  = 8'h24;
  localparam logic [7:0] OFS_RESTART  = 8'h28;

  // ==========================================================================
  // reset values and legal ranges
  localparam logic [15:0] RST_BRK_EN  = 16'h0001;
  localparam logic [15:0] MAX_BRK_EN  = 16'h0001;
  localparam logic [15:0] RST_HOLD_MS = 16'h0096;
  localparam logic [15:0] MIN_HOLD_MS = 16'h0001;
  localparam logic [15:0] MAX_HOLD_MS = 16'h03e8;
  localparam logic [15:0] RST_CMD_MS  = 16'h00fa;
  localparam logic [15:0] MAX_CMD_MS  = 16'h01f4;
  localparam logic [15:0] RST_SPD_THR = 16'h001e;
  localparam logic [15:0] MAX_SPD_THR = 16'h0bb8;
  localparam logic [15:0] RST_WAIT_MS = 16'h01f4;
  localparam logic [15:0] MIN_WAIT_MS = 16'h0001;
  localparam logic [15:0] MAX_WAIT_MS = 16'h03e8;
  localparam logic [15:0] RST_MOT_PAR = 16'h0bb8;
  localparam logic [31:0] RST_DO_FUNC = 32'h0000_0011;
  localparam logic [3:0]  RST_DO_POL  = 4'h0;
  localparam logic [7:0]  FUNC_BRAKE  = 8'h11;

  // ==========================================================================
  // status field positions
  localparam int unsigned ST_BIT_MOTOR  = 0;
  localparam int unsigned ST_BIT_BRAKE  = 1;
  localparam int unsigned ST_BIT_STATIC = 2;
  localparam int unsigned ST_BIT_CMDRDY = 3;
  localparam int unsigned ST_POS_STATE  = 8;

  // ==========================================================================
  // types
  typedef enum logic [4:0] {
    ST_OFF   = 5'b00001,
    ST_RUN   = 5'b00010,
    ST_HOLD  = 5'b00100,
    ST_DECEL = 5'b01000,
    ST_POST  = 5'b10000
  } sbc_state_e;

  typedef struct packed {
    logic [15:0] brk_en;
    logic [15:0] hold_ms;
    logic [15:0] cmd_ms;
    logic [15:0] spd_thr;
    logic [15:0] wait_ms;
  } sbc_cfg_s;

endpackage : sbc_pkg

// ==== core/sbc_ms_timer.sv ====
/*
  sbc_ms_timer: millisecond down-timer with its own prescaler. Assumes start
  is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sbc_ms_timer #(
  parameter int unsigned CYC_PER_MS = 100000
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        start_i,
  input  wire logic [15:0] ms_i,
  // status
  output logic             done_o
);

  // ==========================================================================
  // prescaler and millisecond counter
  logic [31:0] pre_r;
  logic [15:0] ms_r;
  logic        run_r;
  logic        tick;

  assign tick = (pre_r == 32'(CYC_PER_MS - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || start_i) begin
      pre_r <= 32'h0;
    end else if (run_r) begin
      pre_r <= tick ? 32'h0 : pre_r + 32'h1;
    end
  end

  // zero length finishes on the next edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_r   <= 16'h0;
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      ms_r   <= ms_i;
      run_r  <= (ms_i != 16'h0);
      done_o <= (ms_i == 16'h0);
    end else if (run_r && tick) begin
      ms_r <= ms_r - 16'h1;
      if (ms_r == 16'h1) begin
        run_r  <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end

endmodule // sbc_ms_timer

`default_nettype wire

// ==== core/sbc_top.sv ====
/*
  sbc_top: holding-brake control for a servo drive with APB registers.
  Assumes servo enable, fault and measured speed come from logic on the
  same clock, and that the APB master follows the usual two-phase protocol.
*/
`timescale 1ns/1ps
`default_nettype none

module sbc_top
  import sbc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS,
  parameter int unsigned N_DO         = 4
) (
  // clock and reset
  input  wire logic              CLOCK_I,
  input  wire logic              SYS_RST_I,
  // apb slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [7:0]        PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic [31:0]            PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // drive state
  input  wire logic              SERVO_EN_I,
  input  wire logic              FAULT_I,
  input  wire logic [15:0]       SPEED_RPM_I,
  // outputs
  output logic                   MOTOR_PWR_O,
  output logic                   HOLDING_BRAKE_OUTPUT_O,
  output logic                   CMD_READY_O,
  output logic [N_DO-1:0]        DO_O,
  output logic [15:0]            MOTOR_PARAM_O
);

  // ==========================================================================
  // declarations
  sbc_cfg_s          cfg_r;
  sbc_state_e        state_r, state_nxt;
  logic [8*N_DO-1:0] do_func_r;
  logic [N_DO-1:0]   do_pol_r;
  logic [15:0]       mot_stg_r, mot_act_r;
  logic              brake_r, motor_r, restart_r;
  logic              brake_nxt;
  logic              wr, rd_setup, bad_addr, refuse, is_static, is_slow;
  logic              tmr_start, tmr_done, cmd_done;
  logic [15:0]       tmr_ms, wdat;

  assign wdat      = PWDATA_I[15:0];
  assign wr        = PSEL_I && PENABLE_I && PWRITE_I && !PSLVERR_O;
  assign rd_setup  = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign is_static = (SPEED_RPM_I < STATIC_RPM);
  assign is_slow   = (SPEED_RPM_I < cfg_r.spd_thr);

  // ==========================================================================
  // apb decode: zero wait states, errors for bad address or value, or a motor parameter write while running
  assign PREADY_O = 1'b1;

  always_comb begin
    bad_addr = 1'b0;
    refuse   = 1'b0;
    case (PADDR_I)
      OFS_BRK_EN:  refuse = PWRITE_I && (wdat > MAX_BRK_EN);
      OFS_DO_FUNC, OFS_DO_POL, OFS_STATUS, OFS_MOT_ACT, OFS_RESTART: refuse = 1'b0;
      OFS_HOLD_MS: refuse = PWRITE_I && (wdat < MIN_HOLD_MS || wdat > MAX_HOLD_MS);
      OFS_CMD_MS:  refuse = PWRITE_I && (wdat > MAX_CMD_MS);
      OFS_SPD_THR: refuse = PWRITE_I && (wdat > MAX_SPD_THR);
      OFS_WAIT_MS: refuse = PWRITE_I && (wdat < MIN_WAIT_MS || wdat > MAX_WAIT_MS);
      OFS_MOT_STG: refuse = PWRITE_I && (state_r != ST_OFF);
      default:     bad_addr = 1'b1;
    endcase
    PSLVERR_O = PSEL_I && PENABLE_I && (bad_addr || refuse);
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      cfg_r     <= '{RST_BRK_EN, RST_HOLD_MS, RST_CMD_MS, RST_SPD_THR, RST_WAIT_MS};
      do_func_r <= (8*N_DO)'(RST_DO_FUNC);
      do_pol_r  <= N_DO'(RST_DO_POL);
    end else if (wr) begin
      case (PADDR_I)
        OFS_BRK_EN:  cfg_r.brk_en  <= wdat;
        OFS_HOLD_MS: cfg_r.hold_ms <= wdat;
        OFS_CMD_MS:  cfg_r.cmd_ms  <= wdat;
        OFS_SPD_THR: cfg_r.spd_thr <= wdat;
        OFS_WAIT_MS: cfg_r.wait_ms <= wdat;
        OFS_DO_FUNC: do_func_r     <= (8*N_DO)'(PWDATA_I);
        OFS_DO_POL:  do_pol_r      <= N_DO'(PWDATA_I);
        default:     cfg_r.brk_en  <= cfg_r.brk_en;
      endcase
    end
  end

  // staged motor parameter only reaches the control path on a restart
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      mot_stg_r <= RST_MOT_PAR;
      mot_act_r <= RST_MOT_PAR;
      restart_r <= 1'b0;
    end else begin
      restart_r <= wr && (PADDR_I == OFS_RESTART) && PWDATA_I[0];
      if (wr && PADDR_I == OFS_MOT_STG) begin
        mot_stg_r <= wdat;
      end
      if (restart_r) begin
        mot_act_r <= mot_stg_r;
      end
    end
  end

  // ==========================================================================
  // read data, captured in the setup phase
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0;
    end else if (rd_setup) begin
      case (PADDR_I)
        OFS_BRK_EN:  PRDATA_O <= {16'h0, cfg_r.brk_en};
        OFS_DO_FUNC: PRDATA_O <= 32'(do_func_r);
        OFS_DO_POL:  PRDATA_O <= 32'(do_pol_r);
        OFS_HOLD_MS: PRDATA_O <= {16'h0, cfg_r.hold_ms};
        OFS_CMD_MS:  PRDATA_O <= {16'h0, cfg_r.cmd_ms};
        OFS_SPD_THR: PRDATA_O <= {16'h0, cfg_r.spd_thr};
        OFS_WAIT_MS: PRDATA_O <= {16'h0, cfg_r.wait_ms};
        OFS_STATUS:  PRDATA_O <= {19'h0, state_r, 4'h0, CMD_READY_O, is_static,
                                  brake_r, motor_r};
        OFS_MOT_STG: PRDATA_O <= {16'h0, mot_stg_r};
        OFS_MOT_ACT: PRDATA_O <= {16'h0, mot_act_r};
        default:     PRDATA_O <= 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // stop sequencing
  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_ms    = POST_OFF_MS;
    case (state_r)
      ST_OFF: begin
        if (SERVO_EN_I && !FAULT_I) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (FAULT_I) begin
          state_nxt = ST_OFF;
        end else if (!SERVO_EN_I && is_static) begin
          state_nxt = ST_HOLD;
          tmr_start = 1'b1;
          tmr_ms    = cfg_r.hold_ms;
        end else if (!SERVO_EN_I) begin
          state_nxt = ST_DECEL;
          tmr_start = 1'b1;
          tmr_ms    = cfg_r.wait_ms;
        end
      end
      ST_DECEL: begin
        if (FAULT_I) begin
          state_nxt = ST_OFF;
        end else if (is_slow || tmr_done) begin
          state_nxt = ST_POST;
          tmr_start = 1'b1;
        end
      end
      ST_HOLD, ST_POST: begin
        if (FAULT_I || tmr_done) begin
          state_nxt = ST_OFF;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
    if (restart_r) begin
      state_nxt = ST_OFF;
      tmr_start = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // fault path drops power and brake in the same edge, no delay
  // terminals use the next brake value so the pin moves with brake_r
  assign brake_nxt = (cfg_r.brk_en == MAX_BRK_EN) &&
                     (state_nxt == ST_RUN || state_nxt == ST_DECEL);

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      motor_r <= 1'b0;
      brake_r <= 1'b0;
    end else begin
      motor_r <= (state_nxt != ST_OFF);
      brake_r <= brake_nxt;
    end
  end

  // terminals: inactive brake level leaves the brake coil unpowered
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      DO_O <= '0;
    end else begin
      for (int i = 0; i < N_DO; i++) begin
        DO_O[i] <= (do_func_r[8*i +: 8] == FUNC_BRAKE) ? (brake_nxt ^ do_pol_r[i])
                                                        : do_pol_r[i];
      end
    end
  end

  assign MOTOR_PWR_O            = motor_r;
  assign HOLDING_BRAKE_OUTPUT_O = brake_r;
  assign MOTOR_PARAM_O          = mot_act_r;
  assign CMD_READY_O            = (state_r == ST_RUN) && cmd_done;

  // ==========================================================================
  // timers
  sbc_ms_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_seq_tmr (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .start_i (tmr_start),
    .ms_i    (tmr_ms),
    .done_o  (tmr_done)
  );

  sbc_ms_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_cmd_tmr (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .start_i (state_r == ST_OFF && state_nxt == ST_RUN),
    .ms_i    (cfg_r.cmd_ms),
    .done_o  (cmd_done)
  );

  // ==========================================================================
  // assertions
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  a_motor_param_lock: assert property (
    (wr && PADDR_I == OFS_MOT_STG) |-> state_r == ST_OFF ##1 $stable(mot_act_r))
    else $error("motor parameter taken while running or applied early");
  a_brake_off_engaged: assert property (state_r == ST_OFF |-> !brake_r)
    else $error("brake released while drive off");
  a_brake_needs_motor: assert property (brake_r |-> motor_r)
    else $error("brake released without motor power");
  a_static_select: assert property (
    (state_r == ST_RUN && !SERVO_EN_I && !FAULT_I && !restart_r &&
     SPEED_RPM_I < 16'h001e) |=> state_r == ST_HOLD)
    else $error("static stop not selected");
  a_moving_select: assert property (
    (state_r == ST_RUN && !SERVO_EN_I && !FAULT_I && !restart_r &&
     SPEED_RPM_I >= 16'h001e) |=> state_r == ST_DECEL)
    else $error("moving stop not selected");
  a_fault_drop: assert property (
    (FAULT_I && state_r != ST_OFF) |=> (state_r == ST_OFF && !motor_r && !brake_r))
    else $error("fault did not drop power and brake");
  a_enable_write_now: assert property (
    (wr && PADDR_I == OFS_BRK_EN && wdat == 16'h0) |-> ##2 !brake_r)
    else $error("brake enable clear not immediate");
  a_enable_together: assert property (
    ($rose(motor_r) && $past(cfg_r.brk_en) == 16'h1) |-> brake_r)
    else $error("brake and motor not released together");
  // fault or restart may legally cut the hold short
  a_static_hold: assert property (
    disable iff (SYS_RST_I || FAULT_I || restart_r)
    $rose(state_r == ST_HOLD) |-> (!brake_r && motor_r) [*3])
    else $error("static hold sequence wrong");
  a_disable_blocks: assert property (cfg_r.brk_en == 16'h0 |=> !brake_r)
    else $error("brake output active with function disabled");

  c_static_stop: cover property (state_r == ST_HOLD ##1 state_r == ST_OFF);
  c_moving_stop: cover property (state_r == ST_DECEL ##1 state_r == ST_POST);
  c_fault_stop:  cover property (state_r == ST_RUN && FAULT_I);
  c_brake_disabled: cover property (cfg_r.brk_en == 16'h0 && motor_r);
  c_param_restart: cover property (restart_r && mot_stg_r != mot_act_r);

endmodule // sbc_top

`default_nettype wire

// ==== testbench/sbc_motor_model.sv ====
/*
  sbc_motor_model: motor shaft with holding brake, driven by the brake block.
  Assumes the bench sets a target speed and shares the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sbc_motor_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // from the brake block and the host
  input  wire logic        motor_pwr_i,
  input  wire logic        brake_rel_i,
  input  wire logic [15:0] target_i,
  // measured speed
  output logic      [15:0] speed_o
);
  // ==========================================================================
  // shaft speed
  // one rpm per cycle, so the threshold is crossed slowly enough to observe
  always_ff @(posedge clk_i) begin
    if (rst_i || !brake_rel_i) begin
      speed_o <= 16'h0000;
    end else if (motor_pwr_i && speed_o < target_i) begin
      speed_o <= speed_o + 16'h0001;
    end else if (speed_o != 16'h0000 && (!motor_pwr_i || speed_o > target_i)) begin
      speed_o <= speed_o - 16'h0001;
    end
  end
endmodule  // sbc_motor_model
`default_nettype wire

// ==== testbench/tb.sv ====
/*
  tb: self-checking bench for the holding-brake block and a motor model.
  Assumes a 10-cycle millisecond prescale so the timed stops stay short.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import sbc_pkg::*;
;
  // ==========================================================================
  // signals
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        servo_en = 1'b0;
  logic        fault    = 1'b0;
  logic [15:0] target   = 16'h0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] speed;
  logic        motor;
  logic        brake;
  logic        cmd_rdy;
  logic [3:0]  dout;
  logic [15:0] mparam;
  logic [31:0] rd;
  logic        err;
  int          errors    = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  int          n;

  always #5 clk = ~clk;

  sbc_top #(.CYC_PER_MS_P(10), .N_DO(4)) dut (
    .CLOCK_I(clk), .SYS_RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SERVO_EN_I(servo_en), .FAULT_I(fault), .SPEED_RPM_I(speed),
    .MOTOR_PWR_O(motor), .HOLDING_BRAKE_OUTPUT_O(brake), .CMD_READY_O(cmd_rdy),
    .DO_O(dout), .MOTOR_PARAM_O(mparam)
  );

  sbc_motor_model shaft (
    .clk_i(clk), .rst_i(rst), .motor_pwr_i(motor), .brake_rel_i(brake),
    .target_i(target), .speed_o(speed)
  );

  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no cycle budget here: only the bench timeout ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic drv(input logic v);
    @(posedge clk);
    servo_en <= v;
  endtask

  // sample just after an edge so its updates have landed
  task automatic look;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_off;
    n = 0;
    while (motor === 1'b1 && n < 2000) begin
      look;
      n++;
    end
    chk("motor stopped", 32'(motor), 32'h0);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    apb(1'b0, OFS_BRK_EN, 32'h0);
    chk("brk_en reset", rd, 32'h1);
    apb(1'b0, OFS_HOLD_MS, 32'h0);
    chk("hold reset", rd, 32'h96);
    apb(1'b0, OFS_DO_FUNC, 32'h0);
    chk("do_func reset", rd, 32'h11);
    chk("idle brake", 32'(brake), 32'h0);
  endtask

  task automatic t_static;
    apb(1'b1, OFS_DO_FUNC, 32'h0011_0000);
    apb(1'b1, OFS_HOLD_MS, 32'h5);
    apb(1'b1, OFS_CMD_MS, 32'h2);
    target <= 16'h001d;
    drv(1'b1);
    look;
    chk("enable motor", 32'(motor), 32'h1);
    chk("enable brake", 32'(brake), 32'h1);
    chk("do mapped", 32'(dout), 32'h4);
    chk("cmd wait", 32'(cmd_rdy), 32'h0);
    apb(1'b1, OFS_DO_POL, 32'h4);
    look;
    look;
    chk("do polarity", 32'(dout), 32'h0);
    apb(1'b1, OFS_DO_POL, 32'h0);
    repeat (40) @(posedge clk);
    chk("speed ramp", 32'(speed), 32'h1d);
    chk("cmd ready", 32'(cmd_rdy), 32'h1);
    drv(1'b0);
    look;
    chk("static brake", 32'(brake), 32'h0);
    chk("static motor", 32'(motor), 32'h1);
    wait_off;
    chk("hold time", 32'(n >= 47 && n <= 53), 32'h1);
  endtask

  task automatic t_moving;
    @(posedge clk);
    target <= 16'h001e;
    servo_en <= 1'b1;
    repeat (40) @(posedge clk);
    drv(1'b0);
    // boundary speed: brake stays released while the shaft still turns
    repeat (10) begin
      look;
      chk("moving brake", 32'(brake), 32'h1);
    end
    @(posedge clk);
    target <= 16'h0000;
    n = 0;
    while (brake === 1'b1 && n < 100) begin
      look;
      n++;
    end
    chk("brake drop", 32'(n < 5), 32'h1);
    wait_off;
    chk("post hold", 32'(n >= 497 && n <= 503), 32'h1);
  endtask

  task automatic t_fault;
    drv(1'b1);
    repeat (3) look;
    @(posedge clk);
    fault <= 1'b1;
    look;
    chk("fault brake", 32'(brake), 32'h0);
    chk("fault motor", 32'(motor), 32'h0);
    @(posedge clk);
    fault <= 1'b0;
    servo_en <= 1'b0;
  endtask

  task automatic t_brken;
    apb(1'b1, OFS_BRK_EN, 32'h2);
    chk("brk_en range", 32'(err), 32'h1);
    drv(1'b1);
    look;
    apb(1'b1, OFS_BRK_EN, 32'h0);
    look;
    chk("brake forced", 32'(brake), 32'h0);
    chk("motor kept", 32'(motor), 32'h1);
    drv(1'b0);
    wait_off;
    drv(1'b1);
    repeat (5) begin
      look;
      chk("brake never", 32'(brake), 32'h0);
    end
    apb(1'b0, OFS_BRK_EN, 32'h0);
    chk("brk_en read", rd, 32'h0);
    apb(1'b1, OFS_BRK_EN, 32'h1);
  endtask

  task automatic t_motor;
    apb(1'b1, OFS_MOT_STG, 32'h0123);
    chk("param in run", 32'(err), 32'h1);
    drv(1'b0);
    wait_off;
    apb(1'b1, OFS_MOT_STG, 32'h0123);
    chk("param stopped", 32'(err), 32'h0);
    apb(1'b0, OFS_MOT_ACT, 32'h0);
    chk("param pending", rd, 32'h0bb8);
    chk("param port", 32'(mparam), 32'h0bb8);
    apb(1'b1, OFS_RESTART, 32'h1);
    look;
    look;
    apb(1'b0, OFS_MOT_ACT, 32'h0);
    chk("param applied", rd, 32'h0123);
    chk("param port new", 32'(mparam), 32'h0123);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
  endtask

  // ==========================================================================
  // verdict and hang guard
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_static;
    t_moving;
    t_fault;
    t_brken;
    t_motor;
    summarize();
  end
endmodule  // tb
`default_nettype wire
